// ===== lld_regs.svh
// constants of the legacy low memory decoder: offsets, fields, ranges, reset values
// assumes inclusion by the attribute store and decoder design files only
`ifndef LLD_REGS_SVH
`define LLD_REGS_SVH
`define LLD_LAC_OFFSET 8'h97
`define LLD_LAC_RESET 8'h00
`define LLD_LAC_HOLE_BIT 7
`define LLD_LAC_MONO_ADAPTER_PRESENT_BIT_BIT 0
`define LLD_LAC_STEER_BIT 1
`define LLD_VGA_BASE 36'h0000A0000
`define LLD_VGA_LAST 36'h0000BFFFF
`define LLD_MDA_BASE 36'h0000B0000
`define LLD_MDA_LAST 36'h0000B7FFF
`define LLD_PAM_BASE 36'h0000C0000
`define LLD_PAM_LAST 36'h0000FFFFF
`define LLD_FSEG_BASE 36'h0000F0000
`define LLD_SEG_SHIFT 14
`define LLD_SEG_IDX_W 4
`define LLD_FSEG_IDX 4'hC
`define LLD_NUM_SEGS 13
`define LLD_ONE_MB 36'h000100000
`define LLD_HOLE_BASE 36'h000F00000
`define LLD_HOLE_LAST 36'h000FFFFFF
`define LLD_MEM_TOP 36'h200000000
`define LLD_TOP_SMM_SEGMENT_1MB 36'h000100000
`define LLD_TOP_SMM_SEGMENT_2MB 36'h000200000
`define LLD_TOP_SMM_SEGMENT_8MB 36'h000800000
`define LLD_ATTR_RESET 26'h0000000
`define LLD_IO_3B4 16'h03B4
`define LLD_IO_3B5 16'h03B5
`define LLD_IO_3B8 16'h03B8
`define LLD_IO_3B9 16'h03B9
`define LLD_IO_3BA 16'h03BA
`define LLD_IO_3BF 16'h03BF
`define LLD_IO_MASK10 16'h03FF
`define LLD_ZERO_ADDR 36'h000000000
`endif

// ===== lld_pkg.sv
// types of the legacy low memory decoder
// assumes lld_regs.svh holds all numeric constants
package lld_pkg;
  typedef enum logic [1:0] {LLD_SRC_CPU, LLD_SRC_GFX1, LLD_SRC_GFX3, LLD_SRC_SBL} lld_src_t;
  typedef enum logic [2:0] {LLD_DST_NONE, LLD_DST_DRAM, LLD_DST_GFX1, LLD_DST_GFX3,
    LLD_DST_SBL, LLD_DST_INVALID} lld_dst_t;
  typedef struct packed {
    logic valid;
    lld_src_t src;
    logic is_io;
    logic write;
    logic smm;
    logic wb;
    logic snoop;
    logic [35:0] addr;
    logic [7:0] be;
  } lld_req_t;
  typedef struct packed {
    logic valid;
    lld_dst_t dst;
    logic peer;
    logic [35:0] addr;
    logic [7:0] be;
  } lld_rsp_t;
  typedef struct packed {
    logic gfx1_vga_en;
    logic gfx3_vga_en;
    logic gfx1_vga16;
    logic gfx3_vga16;
    logic smm_memory_en;
    logic ext_smm_memory_en;
    logic top_smm_segment_en;
    logic [1:0] top_smm_segment_size;
    logic [35:0] top_low_usable_dram;
  } lld_cfg_t;
endpackage

// ===== lld_seg_attr.sv
// shadow segment attribute store: read and write enable per segment
// assumes configuration writes arrive on the system clock
`timescale 1ns/1ps
`include "lld_regs.svh"
module lld_seg_attr (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic [3:0] i_wr_idx,
  input wire logic [1:0] i_wr_attr,
  input wire logic [3:0] i_rd_idx,
  output logic [1:0] o_rd_attr
);
  typedef struct packed {
    logic [25:0] attr;
    logic [1:0] rd;
  } lld_sa_state_t;
  lld_sa_state_t st_ff;
  lld_sa_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (i_wr && (i_wr_idx < 4'(`LLD_NUM_SEGS))) begin
      nxt_st.attr[2*i_wr_idx +: 2] = i_wr_attr;
    end
    nxt_st.rd = (i_rd_idx < 4'(`LLD_NUM_SEGS)) ? nxt_st.attr[2*i_rd_idx +: 2] : 2'h0;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '{attr: `LLD_ATTR_RESET, rd: 2'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_rd_attr = st_ff.rd;
endmodule // lld_seg_attr

// ===== lld_decoder.sv
// legacy low memory decoder: routes one request per cycle to dram, a graphics port
// or the south bridge link; assumes requests are single cycle pulses on i_clk,
// answer two cycles later (one for attribute lookup, one registered output)
`timescale 1ns/1ps
`include "lld_regs.svh"
// Behaviour
// - legacy video window goes to gfx1, gfx3 or link per enables, steering, mono bit
// - internal resources decoded first, then graphics port versus link
// - smm cpu access to a0000-bffff with smm memory enabled goes to dram
// - non-smm cpu video window access follows legacy video routing
// - port or link cycles to enabled smm memory become peer video cycles
// - monochrome range b0000-b7fff forwarded per steering and mono bit
// - monochrome io ports 3b4,3b5,3b8,3b9,3ba,3bf forwarded the same way
// - each graphics port offers 16-bit video io decode option
// - c0000-dffff is eight 16 KB segments with own attributes
// - disabled segment dram is hidden, never relocated
// - non-snooped port or link access to shadow area always goes to dram
// - e0000-effff is four 16 KB segments choosing dram or link
// - f0000-fffff one segment, disabled after reset, goes to link
// - cpu and snooped port or link accesses to disabled segments default to the link
// - 1 MB to top of low memory goes to dram except smm segment and hole
// - up to 8 GB main memory decoded, no relocation of hidden dram
// - fixed hole bit sends 15-16 MB to the link, dram there unreachable
// - top smm segment of 1, 2 or 8 MB; smm cpu access reaches dram
// - port or link cycles to the top smm segment invalid: address 0, no write enables
// - extended smm: non-smm non-wb cpu access invalid, wb completes to dram
// - memory decode wins over overlapping programmable windows
module lld_decoder (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire lld_pkg::lld_req_t i_req,
  input wire lld_pkg::lld_cfg_t i_cfg,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_offset,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_seg_wr,
  input wire logic [3:0] i_seg_idx,
  input wire logic [1:0] i_seg_attr,
  input wire logic i_win_hit,
  input wire lld_pkg::lld_dst_t i_win_dst,
  output lld_pkg::lld_rsp_t o_rsp,
  output logic [7:0] o_legacy_access_control
);
  typedef struct packed {
    logic [7:0] legacy_access_control;
    lld_pkg::lld_req_t req;
    logic win_hit;
    lld_pkg::lld_dst_t win_dst;
    lld_pkg::lld_rsp_t rsp;
  } lld_dec_state_t;

  lld_dec_state_t st_ff;
  lld_dec_state_t nxt_st;
  logic [1:0] seg_attr;
  logic [3:0] seg_idx_in;
  logic [35:0] pam_off;

  assign pam_off = i_req.addr - `LLD_PAM_BASE;
  assign seg_idx_in = (i_req.addr >= `LLD_FSEG_BASE) ? `LLD_FSEG_IDX :
    pam_off[`LLD_SEG_SHIFT +: `LLD_SEG_IDX_W];

  // attribute lookup registered alongside the request
  lld_seg_attr u_seg_attr (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(i_seg_wr),
    .i_wr_idx(i_seg_idx),
    .i_wr_attr(i_seg_attr),
    .i_rd_idx(seg_idx_in),
    .o_rd_attr(seg_attr)
  );

  // video routing: enabled port wins, mono range steered by steering bit when mono bit set
  function automatic lld_pkg::lld_dst_t vga_route(input logic mono, input logic [7:0] legacy_access_control,
      input lld_pkg::lld_cfg_t cfg);
    lld_pkg::lld_dst_t d;
    d = lld_pkg::LLD_DST_SBL;
    if (cfg.gfx1_vga_en) begin
      d = lld_pkg::LLD_DST_GFX1;
    end else if (cfg.gfx3_vga_en) begin
      d = lld_pkg::LLD_DST_GFX3;
    end
    if (mono && legacy_access_control[`LLD_LAC_MONO_ADAPTER_PRESENT_BIT_BIT]) begin
      if (!cfg.gfx1_vga_en && !cfg.gfx3_vga_en) begin
        d = lld_pkg::LLD_DST_SBL;
      end else begin
        d = legacy_access_control[`LLD_LAC_STEER_BIT] ? lld_pkg::LLD_DST_GFX3 : lld_pkg::LLD_DST_GFX1;
      end
    end
    return d;
  endfunction

  logic [35:0] top_smm_segment_sz;
  logic [35:0] top_smm_segment_base;
  logic is_cpu;
  logic is_vga;
  logic is_mda;
  logic is_pam;
  logic is_top_smm_segment;
  logic is_hole;
  logic is_main;
  logic mda_io;
  logic [15:0] io_a;

  always_comb begin
    case (i_cfg.top_smm_segment_size)
      2'h0: top_smm_segment_sz = `LLD_TOP_SMM_SEGMENT_1MB;
      2'h1: top_smm_segment_sz = `LLD_TOP_SMM_SEGMENT_2MB;
      default: top_smm_segment_sz = `LLD_TOP_SMM_SEGMENT_8MB;
    endcase
  end

  assign top_smm_segment_base = i_cfg.top_low_usable_dram - top_smm_segment_sz;
  assign is_cpu = (st_ff.req.src == lld_pkg::LLD_SRC_CPU);
  assign is_vga = (st_ff.req.addr >= `LLD_VGA_BASE) && (st_ff.req.addr <= `LLD_VGA_LAST);
  assign is_mda = (st_ff.req.addr >= `LLD_MDA_BASE) && (st_ff.req.addr <= `LLD_MDA_LAST);
  assign is_pam = (st_ff.req.addr >= `LLD_PAM_BASE) && (st_ff.req.addr <= `LLD_PAM_LAST);
  assign is_top_smm_segment = i_cfg.top_smm_segment_en && (st_ff.req.addr >= top_smm_segment_base) &&
    (st_ff.req.addr < i_cfg.top_low_usable_dram);
  assign is_hole = st_ff.legacy_access_control[`LLD_LAC_HOLE_BIT] && (st_ff.req.addr >= `LLD_HOLE_BASE) &&
    (st_ff.req.addr <= `LLD_HOLE_LAST);
  assign is_main = (st_ff.req.addr >= `LLD_ONE_MB) && (st_ff.req.addr < i_cfg.top_low_usable_dram) &&
    (st_ff.req.addr < `LLD_MEM_TOP);

  // 16-bit option compares all address bits, otherwise only ten
  always_comb begin
    logic sixteen;
    sixteen = (vga_route(1'b1, st_ff.legacy_access_control, i_cfg) == lld_pkg::LLD_DST_GFX3) ?
      i_cfg.gfx3_vga16 : i_cfg.gfx1_vga16;
    io_a = sixteen ? st_ff.req.addr[15:0] : (st_ff.req.addr[15:0] & `LLD_IO_MASK10);
    mda_io = (io_a == `LLD_IO_3B4) || (io_a == `LLD_IO_3B5) || (io_a == `LLD_IO_3B8) ||
      (io_a == `LLD_IO_3B9) || (io_a == `LLD_IO_3BA) || (io_a == `LLD_IO_3BF);
  end

  always_comb begin
    nxt_st = st_ff;
    if (i_cfg_wr && (i_cfg_offset == `LLD_LAC_OFFSET)) begin
      nxt_st.legacy_access_control = i_cfg_wdata;
    end
    nxt_st.req = i_req;
    nxt_st.win_hit = i_win_hit;
    nxt_st.win_dst = i_win_dst;
    nxt_st.rsp.valid = st_ff.req.valid;
    nxt_st.rsp.peer = 1'b0;
    nxt_st.rsp.addr = st_ff.req.addr;
    nxt_st.rsp.be = st_ff.req.be;
    nxt_st.rsp.dst = lld_pkg::LLD_DST_NONE;
    if (st_ff.req.valid) begin
      if (st_ff.req.is_io) begin
        nxt_st.rsp.dst = mda_io ? vga_route(1'b1, st_ff.legacy_access_control, i_cfg) : lld_pkg::LLD_DST_SBL;
      end else if (is_vga) begin
        // internal smm claim before any port choice
        if (i_cfg.smm_memory_en && is_cpu && st_ff.req.smm) begin
          nxt_st.rsp.dst = lld_pkg::LLD_DST_DRAM;
        end else begin
          nxt_st.rsp.dst = vga_route(is_mda, st_ff.legacy_access_control, i_cfg);
          nxt_st.rsp.peer = !is_cpu && i_cfg.smm_memory_en;
        end
      end else if (is_pam) begin
        if (!is_cpu && !st_ff.req.snoop) begin
          nxt_st.rsp.dst = lld_pkg::LLD_DST_DRAM;
        end else if (st_ff.req.write ? seg_attr[1] : seg_attr[0]) begin
          nxt_st.rsp.dst = lld_pkg::LLD_DST_DRAM;
        end else begin
          nxt_st.rsp.dst = lld_pkg::LLD_DST_SBL;
        end
      end else if (is_top_smm_segment) begin
        if (!is_cpu) begin
          nxt_st.rsp.dst = lld_pkg::LLD_DST_INVALID;
          nxt_st.rsp.addr = `LLD_ZERO_ADDR;
          nxt_st.rsp.be = 8'h00;
        end else if (st_ff.req.smm || st_ff.req.wb || !i_cfg.ext_smm_memory_en) begin
          nxt_st.rsp.dst = lld_pkg::LLD_DST_DRAM;
        end else begin
          nxt_st.rsp.dst = lld_pkg::LLD_DST_INVALID;
        end
      end else if (is_hole) begin
        nxt_st.rsp.dst = lld_pkg::LLD_DST_SBL;
      end else if (is_main || (st_ff.req.addr < `LLD_ONE_MB)) begin
        nxt_st.rsp.dst = lld_pkg::LLD_DST_DRAM;
      end else if (st_ff.win_hit) begin
        nxt_st.rsp.dst = st_ff.win_dst;
      end else begin
        nxt_st.rsp.dst = lld_pkg::LLD_DST_SBL;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rsp = st_ff.rsp;
  assign o_legacy_access_control = st_ff.legacy_access_control;

  logic mem_req;
  assign mem_req = st_ff.req.valid && !st_ff.req.is_io;

  sequence smm_cpu_vga_s;
    st_ff.req.valid && is_vga && !st_ff.req.is_io && is_cpu && st_ff.req.smm && i_cfg.smm_memory_en;
  endsequence
  sequence peer_vga_s;
    st_ff.req.valid && is_vga && !st_ff.req.is_io && !is_cpu && i_cfg.smm_memory_en;
  endsequence

  smm_vga_dram_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    smm_cpu_vga_s |=> (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("smm vga access not sent to dram");
  peer_vga_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    peer_vga_s |=> (o_rsp.peer && o_rsp.dst != lld_pkg::LLD_DST_DRAM))
    else $error("port cycle to smm memory reached dram");
  top_smm_segment_invalid_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_ff.req.valid && !st_ff.req.is_io && is_top_smm_segment && !is_vga && !is_pam && !is_cpu) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_INVALID && o_rsp.addr == `LLD_ZERO_ADDR && o_rsp.be == 8'h00))
    else $error("top_smm_segment port cycle not invalidated");
  nonsnoop_dram_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_ff.req.valid && !st_ff.req.is_io && is_pam && !is_cpu && !st_ff.req.snoop) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("non-snooped shadow access missed dram");
  hole_link_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_ff.req.valid && !st_ff.req.is_io && is_hole && !is_top_smm_segment) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_SBL))
    else $error("hole access not sent to link");
  answer_timing_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_req.valid |-> ##2 o_rsp.valid)
    else $error("answer not two cycles after request");
  fseg_reset_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($past(i_sys_rst) && i_req.valid && !i_req.is_io && i_req.src == lld_pkg::LLD_SRC_CPU &&
    i_req.addr >= `LLD_FSEG_BASE && i_req.addr <= `LLD_PAM_LAST && !i_seg_wr) |->
    ##2 (o_rsp.dst == lld_pkg::LLD_DST_SBL))
    else $error("bios segment not on link after reset");
  lac_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_cfg_wr && i_cfg_offset == `LLD_LAC_OFFSET) |=>
    (o_legacy_access_control == $past(i_cfg_wdata)))
    else $error("legacy access control write lost");
  mda_io_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_ff.req.valid && st_ff.req.is_io && mda_io && i_cfg.gfx1_vga_en &&
    !st_ff.legacy_access_control[`LLD_LAC_MONO_ADAPTER_PRESENT_BIT_BIT])
    |=> (o_rsp.dst == lld_pkg::LLD_DST_GFX1))
    else $error("mono io port misrouted");
  vga_gfx1_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_vga && !is_mda && is_cpu && !i_cfg.smm_memory_en && i_cfg.gfx1_vga_en) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_GFX1))
    else $error("video window not sent to graphics port 1");
  vga_none_link_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_vga && is_cpu && !st_ff.req.smm && !i_cfg.gfx1_vga_en && !i_cfg.gfx3_vga_en)
    |=> (o_rsp.dst == lld_pkg::LLD_DST_SBL))
    else $error("video window without enabled port not sent to link");
  mono_steer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_mda && !(is_cpu && st_ff.req.smm && i_cfg.smm_memory_en) && i_cfg.gfx3_vga_en &&
    st_ff.legacy_access_control[`LLD_LAC_MONO_ADAPTER_PRESENT_BIT_BIT] && st_ff.legacy_access_control[`LLD_LAC_STEER_BIT]) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_GFX3))
    else $error("mono range not steered to graphics port 3");
  io_other_link_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_ff.req.valid && st_ff.req.is_io && !mda_io) |=> (o_rsp.dst == lld_pkg::LLD_DST_SBL))
    else $error("non mono io port not sent to link");
  io_alias_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_ff.req.valid && st_ff.req.is_io && i_cfg.gfx1_vga_en && !i_cfg.gfx3_vga_en &&
    !i_cfg.gfx1_vga16 && !st_ff.legacy_access_control[`LLD_LAC_STEER_BIT] &&
    ((st_ff.req.addr[15:0] & `LLD_IO_MASK10) == `LLD_IO_3B4)) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_GFX1))
    else $error("ten bit io alias not decoded");
  shadow_read_dram_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_pam && is_cpu && !st_ff.req.write && seg_attr[0]) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("read enabled segment not sent to dram");
  shadow_write_link_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_pam && is_cpu && st_ff.req.write && !seg_attr[1]) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_SBL))
    else $error("write disabled segment not sent to link");
  main_dram_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_main && !is_top_smm_segment && !is_hole) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("main memory access missed dram");
  dos_dram_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && !is_top_smm_segment && (st_ff.req.addr < `LLD_VGA_BASE)) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("low memory access missed dram");
  top_smm_dram_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_top_smm_segment && !is_vga && !is_pam && is_cpu && st_ff.req.smm) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("smm access to top segment missed dram");
  top_smm_inval_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_top_smm_segment && !is_vga && !is_pam && is_cpu && !st_ff.req.smm &&
    !st_ff.req.wb && i_cfg.ext_smm_memory_en) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_INVALID))
    else $error("non smm access to top segment not invalidated");
  top_smm_wb_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_top_smm_segment && !is_vga && !is_pam && is_cpu && st_ff.req.wb) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("write-back to top segment missed dram");
  win_overlap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && is_main && !is_top_smm_segment && !is_hole && st_ff.win_hit) |=>
    (o_rsp.dst == lld_pkg::LLD_DST_DRAM))
    else $error("window overlapping memory took the access");
  above_top_win_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mem_req && st_ff.win_hit && (st_ff.req.addr >= i_cfg.top_low_usable_dram) &&
    (st_ff.req.addr >= `LLD_ONE_MB) && !is_hole) |=>
    (o_rsp.dst == $past(st_ff.win_dst)))
    else $error("window above top of memory misrouted");
endmodule // lld_decoder

// ===== lld_far_end.sv
// far end model: collects the answers that the decoder routes outward
// assumes one answer pulse per accepted request on i_clk
`timescale 1ns/1ps
module lld_far_end (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire lld_pkg::lld_rsp_t i_rsp,
  output logic [15:0] o_count
);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_count <= 16'h0000;
    end else if (i_rsp.valid) begin
      o_count <= o_count + 16'h0001;
    end
  end
endmodule // lld_far_end

// ===== legacy_low_memory_decoder_tb.sv
// self-checking bench of the legacy low memory decoder
// assumes lld_decoder answers two cycles after a request, lld_far_end beside it
`timescale 1ns/1ps
module legacy_low_memory_decoder_tb;
  localparam lld_pkg::lld_src_t cpu = lld_pkg::LLD_SRC_CPU;
  localparam lld_pkg::lld_src_t gfx = lld_pkg::LLD_SRC_GFX1;
  localparam lld_pkg::lld_src_t lnk = lld_pkg::LLD_SRC_SBL;
  localparam lld_pkg::lld_dst_t dram = lld_pkg::LLD_DST_DRAM;
  localparam lld_pkg::lld_dst_t to_g1 = lld_pkg::LLD_DST_GFX1;
  localparam lld_pkg::lld_dst_t to_g3 = lld_pkg::LLD_DST_GFX3;
  localparam lld_pkg::lld_dst_t to_sbl = lld_pkg::LLD_DST_SBL;
  localparam lld_pkg::lld_dst_t inval = lld_pkg::LLD_DST_INVALID;
  // flags {io, write, smm, wb, snoop}
  localparam logic [4:0] rd = 5'h01;
  localparam logic [4:0] wr = 5'h09;
  localparam logic [4:0] smm = 5'h05;
  localparam logic [4:0] ns = 5'h00;
  localparam logic [4:0] wb = 5'h0B; // write-back only toward dram ranges
  localparam logic [4:0] io = 5'h10;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  lld_pkg::lld_req_t i_req = '0;
  lld_pkg::lld_cfg_t i_cfg = '0;
  logic i_cfg_wr = 1'h0;
  logic [7:0] i_cfg_offset = 8'h00;
  logic [7:0] i_cfg_wdata = 8'h00;
  logic i_seg_wr = 1'h0;
  logic [3:0] i_seg_idx = 4'h0;
  logic [1:0] i_seg_attr = 2'h0;
  logic i_win_hit = 1'h0;
  lld_pkg::lld_dst_t i_win_dst = lld_pkg::LLD_DST_NONE;
  lld_pkg::lld_rsp_t o_rsp;
  logic [7:0] o_legacy_access_control;
  logic [15:0] rsp_count;
  int fail_count = 0;
  int n_tests = 0;
  int n_req = 0;
  int cycles = 0;
  lld_decoder lld_decoder_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
    .i_cfg(i_cfg), .i_cfg_wr(i_cfg_wr), .i_cfg_offset(i_cfg_offset),
    .i_cfg_wdata(i_cfg_wdata), .i_seg_wr(i_seg_wr), .i_seg_idx(i_seg_idx),
    .i_seg_attr(i_seg_attr), .i_win_hit(i_win_hit), .i_win_dst(i_win_dst),
    .o_rsp(o_rsp), .o_legacy_access_control(o_legacy_access_control));
  lld_far_end lld_far_end_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rsp(o_rsp),
    .o_count(rsp_count));
  always #2.5 i_clk = ~i_clk;
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // entered at a falling edge; returns at the falling edge where the answer stands
  task automatic go(input lld_pkg::lld_src_t s, input logic [4:0] f, input logic [35:0] a);
    i_req = '{1'h1, s, f[4], f[3], f[2], f[1], f[0], a, 8'hFF};
    n_req++;
    @(negedge i_clk);
    i_req.valid = 1'h0;
    @(negedge i_clk);
  endtask
  task automatic rt(input lld_pkg::lld_src_t s, input logic [4:0] f, input logic [35:0] a,
      input lld_pkg::lld_dst_t d);
    go(s, f, a);
    chk("dst", o_rsp.dst, d);
  endtask
  task automatic reg_wr(input logic [7:0] off, input logic [7:0] d);
    i_cfg_wr = 1'h1;
    i_cfg_offset = off;
    i_cfg_wdata = d;
    @(negedge i_clk);
    i_cfg_wr = 1'h0;
    @(negedge i_clk);
  endtask
  task automatic seg_wr(input logic [3:0] idx, input logic [1:0] at);
    i_seg_wr = 1'h1;
    i_seg_idx = idx;
    i_seg_attr = at;
    @(negedge i_clk);
    i_seg_wr = 1'h0;
    @(negedge i_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_video;
    chk("lac", o_legacy_access_control, 36'h0);
    rt(cpu, rd, 36'hF0000, to_sbl);
    i_cfg.gfx1_vga_en = 1'h1; // one port only
    rt(cpu, rd, 36'hA0000, to_g1);
    i_cfg.gfx1_vga_en = 1'h0;
    i_cfg.gfx3_vga_en = 1'h1;
    rt(cpu, wr, 36'hBFFFF, to_g3);
    i_cfg.smm_memory_en = 1'h1;
    rt(cpu, smm, 36'hBFFFF, dram);
    chk("addr", o_rsp.addr, 36'hBFFFF);
    rt(cpu, rd, 36'hA0000, to_g3);
    go(lnk, wr, 36'hA0000);
    chk("peer", o_rsp.peer, 36'h1);
    chk("not dram", o_rsp.dst == dram, 36'h0);
    i_cfg.smm_memory_en = 1'h0;
    i_cfg.gfx3_vga_en = 1'h0;
    rt(cpu, rd, 36'hAFFFF, to_sbl);
    $display("video done");
  endtask
  task automatic t_mono;
    logic [15:0] ports [6];
    ports = '{16'h03B4, 16'h03B5, 16'h03B8, 16'h03B9, 16'h03BA, 16'h03BF};
    i_cfg.gfx1_vga_en = 1'h1;
    rt(cpu, io, 36'h3BA, to_g1);
    reg_wr(8'h97, 8'h01);
    chk("lac", o_legacy_access_control, 36'h01);
    reg_wr(8'h96, 8'hFE);
    chk("lac", o_legacy_access_control, 36'h01);
    rt(cpu, rd, 36'hB0000, to_g1);
    foreach (ports[i]) rt(cpu, io, {20'h0, ports[i]}, to_g1);
    rt(cpu, io, 36'h3B6, to_sbl);
    rt(cpu, io, 36'h7B4, to_g1);
    i_cfg.gfx1_vga16 = 1'h1;
    rt(cpu, io, 36'h7B4, to_sbl);
    i_cfg.gfx1_vga_en = 1'h0;
    i_cfg.gfx3_vga_en = 1'h1;
    reg_wr(8'h97, 8'h03);
    rt(cpu, wr, 36'hB7FFF, to_g3);
    i_cfg.gfx3_vga_en = 1'h0;
    $display("mono done");
  endtask
  task automatic t_pam;
    rt(cpu, rd, 36'hC0000, to_sbl);
    rt(gfx, ns, 36'hC0000, dram);
    seg_wr(4'hC, 2'h1);
    rt(cpu, rd, 36'hF8000, dram);
    rt(cpu, wr, 36'hF8000, to_sbl);
    seg_wr(4'h7, 2'h2);
    rt(cpu, wr, 36'hDFFFF, dram);
    rt(cpu, rd, 36'hDC000, to_sbl);
    rt(cpu, wr, 36'hD8000, to_sbl);
    seg_wr(4'hB, 2'h3);
    rt(lnk, rd, 36'hEC000, dram);
    rt(lnk, rd, 36'hE8000, to_sbl);
    seg_wr(4'hD, 2'h3);
    rt(cpu, rd, 36'hC0000, to_sbl);
    $display("pam done");
  endtask
  task automatic t_main;
    i_cfg.top_low_usable_dram = 36'h004000000;
    rt(cpu, rd, 36'h100000, dram);
    rt(cpu, rd, 36'h9FFFF, dram);
    rt(cpu, rd, 36'hF00000, dram);
    reg_wr(8'h97, 8'h80);
    rt(cpu, wr, 36'hF00000, to_sbl);
    rt(lnk, rd, 36'hFFFFFF, to_sbl);
    rt(cpu, rd, 36'h1000000, dram);
    i_cfg.top_smm_segment_en = 1'h1;
    rt(cpu, smm, 36'h3F00000, dram);
    rt(cpu, rd, 36'h3EFFFFF, dram);
    go(gfx, wr, 36'h3FFFFF8);
    chk("dst", o_rsp.dst, inval);
    chk("addr", o_rsp.addr, 36'h0);
    chk("be", o_rsp.be, 36'h0);
    i_cfg.top_smm_segment_size = 2'h2;
    rt(lnk, rd, 36'h3800000, inval);
    i_cfg.top_smm_segment_size = 2'h1;
    rt(lnk, rd, 36'h3DFFFFF, dram);
    i_cfg.ext_smm_memory_en = 1'h1;
    rt(cpu, wr, 36'h3E00000, inval);
    rt(cpu, wb, 36'h3E00000, dram);
    i_win_hit = 1'h1;
    i_win_dst = to_g1;
    rt(cpu, rd, 36'h2000000, dram);
    rt(cpu, rd, 36'h4000000, to_g1);
    i_win_hit = 1'h0;
    $display("main done");
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'h0;
    t_video();
    t_mono();
    t_pam();
    t_main();
    @(negedge i_clk);
    chk("answers", {20'h0, rsp_count}, n_req);
    test_done();
  end
endmodule // legacy_low_memory_decoder_tb
